// ==== common/dlc_defines.svh ====
`ifndef DLC_DEFINES_SVH
`define DLC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define DLC_ADDR_CH2_CTRL    8'h51
`define DLC_ADDR_CH1_CODE    8'h58
`define DLC_ADDR_CH2_CODE    8'h59
`define DLC_ADDR_CH1_UPPER   8'h60
`define DLC_ADDR_CH2_UPPER   8'h61
`define DLC_ADDR_CH1_LOWER   8'h68
`define DLC_ADDR_CH2_LOWER   8'h69
`define DLC_ADDR_STATUS      8'h70

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DLC_CTRL_ENABLE_BIT  2
`define DLC_CTRL_OFFSET_HI   1
`define DLC_CTRL_OFFSET_LO   0
`define DLC_CTRL_USED_MASK   8'h07
`define DLC_STAT_LOADED_BIT  0
`define DLC_STAT_CH1_ON_BIT  1
`define DLC_STAT_CH2_ON_BIT  2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DLC_RST_CODE         8'h7f
`define DLC_RST_CTRL         8'h00
`define DLC_RST_UPPER        8'h00
`define DLC_RST_LOWER        8'hff

// ----------------------------------------------------------------------------
// Startup image of the limit store and its slot order
// ----------------------------------------------------------------------------
`define DLC_NV_UPPER         8'hff
`define DLC_NV_LOWER         8'h00
`define DLC_SLOT_CH1_UPPER   2'h0
`define DLC_SLOT_CH2_UPPER   2'h1
`define DLC_SLOT_CH1_LOWER   2'h2
`define DLC_SLOT_CH2_LOWER   2'h3

`endif

// ==== common/dlc_pkg.sv ====
`default_nettype none

package dlc_pkg;

    // One register byte.
    typedef logic [7:0] dlc_byte_t;

    // Startup loader states.
    typedef enum logic [1:0] {
        LD_REQ,
        LD_CAPT,
        LD_DONE
    } dlc_load_e;

endpackage

`default_nettype wire

// ==== rtl/dlc_clamp.sv ====
`timescale 1ns/1ps
`default_nettype none

// Limits one channel code between its lower and upper bounds.
module dlc_clamp
    import dlc_pkg::*;
(
    input  wire dlc_byte_t i_code,
    input  wire dlc_byte_t i_upper,
    input  wire dlc_byte_t i_lower,
    output var  dlc_byte_t o_code,
    output var  logic      o_inverted
);

    // ------------------------------------------------------------------------
    // Comparisons
    // ------------------------------------------------------------------------
    wire logic above_w = i_code > i_upper;
    wire logic below_w = i_code < i_lower;

    // Upper bound is checked first; when both apply the bounds are inverted
    // and the channel is off, but the upper bound still reaches the code output.
    assign o_code = above_w ? i_upper :
                    below_w ? i_lower :
                    i_code;
    assign o_inverted = i_lower > i_upper;

endmodule // dlc_clamp
`default_nettype wire

// ==== rtl/dlc_limit_store.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defines.svh"

// Nonvolatile image of the four limit bytes; read data come from a register.
module dlc_limit_store
    import dlc_pkg::*;
#(
    parameter dlc_byte_t CH1_UPPER = `DLC_NV_UPPER,
    parameter dlc_byte_t CH2_UPPER = `DLC_NV_UPPER,
    parameter dlc_byte_t CH1_LOWER = `DLC_NV_LOWER,
    parameter dlc_byte_t CH2_LOWER = `DLC_NV_LOWER
) (
    input  wire logic       i_clk,
    input  wire logic [1:0] i_addr,
    output var  dlc_byte_t  o_rdata
);

    // ------------------------------------------------------------------------
    // Storage and registered read
    // ------------------------------------------------------------------------
    dlc_byte_t mem_w [4];
    dlc_byte_t rdata_ff;

    assign mem_w[`DLC_SLOT_CH1_UPPER] = CH1_UPPER;
    assign mem_w[`DLC_SLOT_CH2_UPPER] = CH2_UPPER;
    assign mem_w[`DLC_SLOT_CH1_LOWER] = CH1_LOWER;
    assign mem_w[`DLC_SLOT_CH2_LOWER] = CH2_LOWER;

    // One cycle of read latency, like a real array.
    always_ff @(posedge i_clk) begin
        rdata_ff <= mem_w[i_addr];
    end

    assign o_rdata = rdata_ff;

endmodule // dlc_limit_store
`default_nettype wire

// ==== rtl/dlc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defines.svh"

module dlc_top
    import dlc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire dlc_byte_t  i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output var  dlc_byte_t  o_rdata,
    output var  dlc_byte_t  o_ch1_code,
    output var  logic       o_ch1_on,
    output var  dlc_byte_t  o_ch2_code,
    output var  logic       o_ch2_on,
    output var  logic [1:0] o_ch2_offset_sel,
    output var  logic       o_load_done
);

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction

    wire logic wr_ctrl2_w  = i_wr && hit(i_addr, `DLC_ADDR_CH2_CTRL);
    wire logic wr_code1_w  = i_wr && hit(i_addr, `DLC_ADDR_CH1_CODE);
    wire logic wr_code2_w  = i_wr && hit(i_addr, `DLC_ADDR_CH2_CODE);
    wire logic wr_upper1_w = i_wr && hit(i_addr, `DLC_ADDR_CH1_UPPER);
    wire logic wr_upper2_w = i_wr && hit(i_addr, `DLC_ADDR_CH2_UPPER);
    wire logic wr_lower1_w = i_wr && hit(i_addr, `DLC_ADDR_CH1_LOWER);
    wire logic wr_lower2_w = i_wr && hit(i_addr, `DLC_ADDR_CH2_LOWER);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    dlc_byte_t ctrl2_ff;
    dlc_byte_t code1_ff;
    dlc_byte_t code2_ff;
    dlc_byte_t upper1_ff;
    dlc_byte_t upper2_ff;
    dlc_byte_t lower1_ff;
    dlc_byte_t lower2_ff;
    dlc_byte_t rdata_ff;
    dlc_byte_t out_code1_ff;
    dlc_byte_t out_code2_ff;
    logic      out_on1_ff;
    logic      out_on2_ff;

    // ------------------------------------------------------------------------
    // Startup limit loader
    // ------------------------------------------------------------------------
    dlc_load_e load_state_ff;
    dlc_load_e nxt_load_state;
    logic [1:0] slot_ff;
    logic [1:0] nxt_slot;
    dlc_byte_t  nv_data_w;

    dlc_limit_store u_store (
        .i_clk   (i_clk),
        .i_addr  (slot_ff),
        .o_rdata (nv_data_w)
    );

    wire logic capt_w    = (load_state_ff == LD_CAPT);
    wire logic loaded_w  = (load_state_ff == LD_DONE);
    wire logic ld_up1_w  = capt_w && (slot_ff == `DLC_SLOT_CH1_UPPER);
    wire logic ld_up2_w  = capt_w && (slot_ff == `DLC_SLOT_CH2_UPPER);
    wire logic ld_lo1_w  = capt_w && (slot_ff == `DLC_SLOT_CH1_LOWER);
    wire logic ld_lo2_w  = capt_w && (slot_ff == `DLC_SLOT_CH2_LOWER);

    // Each slot takes a request cycle and a capture cycle; the store's read
    // latency is the reason for the split.
    always_comb begin
        nxt_load_state = load_state_ff;
        nxt_slot       = slot_ff;
        case (load_state_ff)
            LD_REQ: begin
                nxt_load_state = LD_CAPT;
            end
            LD_CAPT: begin
                if (slot_ff == `DLC_SLOT_CH2_LOWER) begin
                    nxt_load_state = LD_DONE;
                end else begin
                    nxt_load_state = LD_REQ;
                    nxt_slot       = slot_ff + 2'h1;
                end
            end
            LD_DONE: begin
                nxt_load_state = LD_DONE;
            end
            default: begin
                nxt_load_state = LD_REQ;
                nxt_slot       = 2'h0;
            end
        endcase
    end

    // Loader state; it runs once after each reset.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            load_state_ff <= LD_REQ;
            slot_ff       <= 2'h0;
        end else begin
            load_state_ff <= nxt_load_state;
            slot_ff       <= nxt_slot;
        end
    end

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    // Codes and control; only the three used control bits are stored.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl2_ff <= `DLC_RST_CTRL;
            code1_ff <= `DLC_RST_CODE;
            code2_ff <= `DLC_RST_CODE;
        end else begin
            if (wr_ctrl2_w) ctrl2_ff <= i_wdata & `DLC_CTRL_USED_MASK;
            if (wr_code1_w) code1_ff <= i_wdata;
            if (wr_code2_w) code2_ff <= i_wdata;
        end
    end

    // Limits reset to an inverted pair, so both outputs stay off until the
    // first startup capture; channel one comes on once its upper limit lands,
    // before its lower limit. A startup capture beats a bus write.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            upper1_ff <= `DLC_RST_UPPER;
            upper2_ff <= `DLC_RST_UPPER;
            lower1_ff <= `DLC_RST_LOWER;
            lower2_ff <= `DLC_RST_LOWER;
        end else begin
            if (ld_up1_w) upper1_ff <= nv_data_w;
            else if (wr_upper1_w) upper1_ff <= i_wdata;
            if (ld_up2_w) upper2_ff <= nv_data_w;
            else if (wr_upper2_w) upper2_ff <= i_wdata;
            if (ld_lo1_w) lower1_ff <= nv_data_w;
            else if (wr_lower1_w) lower1_ff <= i_wdata;
            if (ld_lo2_w) lower2_ff <= nv_data_w;
            else if (wr_lower2_w) lower2_ff <= i_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Clamp and output gating
    // ------------------------------------------------------------------------
    dlc_byte_t lim_code1_w;
    dlc_byte_t lim_code2_w;
    logic      inv1_w;
    logic      inv2_w;

    dlc_clamp u_clamp1 (
        .i_code     (code1_ff),
        .i_upper    (upper1_ff),
        .i_lower    (lower1_ff),
        .o_code     (lim_code1_w),
        .o_inverted (inv1_w)
    );

    dlc_clamp u_clamp2 (
        .i_code     (code2_ff),
        .i_upper    (upper2_ff),
        .i_lower    (lower2_ff),
        .o_code     (lim_code2_w),
        .o_inverted (inv2_w)
    );

    // Channel one has no enable bit here, so only its limits gate it.
    wire logic on1_w = !inv1_w;
    wire logic on2_w = ctrl2_ff[`DLC_CTRL_ENABLE_BIT] && !inv2_w;

    // Converter codes and on flags are registered: one cycle after any change; the offset select is not.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            out_code1_ff <= `DLC_RST_CODE;
            out_code2_ff <= `DLC_RST_CODE;
            out_on1_ff   <= 1'b0;
            out_on2_ff   <= 1'b0;
        end else begin
            out_code1_ff <= lim_code1_w;
            out_code2_ff <= lim_code2_w;
            out_on1_ff   <= on1_w;
            out_on2_ff   <= on2_w;
        end
    end

    assign o_ch1_code       = out_code1_ff;
    assign o_ch2_code       = out_code2_ff;
    assign o_ch1_on         = out_on1_ff;
    assign o_ch2_on         = out_on2_ff;
    assign o_ch2_offset_sel = ctrl2_ff[`DLC_CTRL_OFFSET_HI:`DLC_CTRL_OFFSET_LO];
    assign o_load_done      = loaded_w;

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    dlc_byte_t status_w;
    dlc_byte_t rd_mux_w;

    assign status_w = {5'h00, out_on2_ff, out_on1_ff, loaded_w};
    assign rd_mux_w =
        hit(i_addr, `DLC_ADDR_CH2_CTRL)  ? ctrl2_ff  :
        hit(i_addr, `DLC_ADDR_CH1_CODE)  ? code1_ff  :
        hit(i_addr, `DLC_ADDR_CH2_CODE)  ? code2_ff  :
        hit(i_addr, `DLC_ADDR_CH1_UPPER) ? upper1_ff :
        hit(i_addr, `DLC_ADDR_CH2_UPPER) ? upper2_ff :
        hit(i_addr, `DLC_ADDR_CH1_LOWER) ? lower1_ff :
        hit(i_addr, `DLC_ADDR_CH2_LOWER) ? lower2_ff :
        hit(i_addr, `DLC_ADDR_STATUS)    ? status_w  : 8'h00;

    // Data stand only in the cycle after the strobe; zero otherwise.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= i_rd ? rd_mux_w : 8'h00;
        end
    end

    assign o_rdata = rdata_ff;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence code2_write_s;
        wr_code2_w;
    endsequence

    sequence code2_held_s;
        !wr_code2_w && !wr_upper2_w && !wr_lower2_w && loaded_w;
    endsequence

    code_store_a: assert property (
        code2_write_s |=> (code2_ff == $past(i_wdata)))
        else $error("Channel two code did not store the written byte.");

    upper_clamp_a: assert property (
        (loaded_w && code2_ff > upper2_ff && !inv2_w) ##0 code2_held_s
        |=> (o_ch2_code == $past(upper2_ff)) && (code2_ff > o_ch2_code))
        else $error("Code above upper limit was not clamped to it.");

    lower_clamp_a: assert property (
        (loaded_w && code1_ff < lower1_ff && !inv1_w)
        |=> (o_ch1_code == $past(lower1_ff)))
        else $error("Code below lower limit was not raised to it.");

    inverted_off_a: assert property (
        (lower2_ff > upper2_ff) |=> !o_ch2_on)
        else $error("Channel two on while its limits are inverted.");

    enable_bit_a: assert property (
        (ctrl2_ff[`DLC_CTRL_ENABLE_BIT] && lower2_ff <= upper2_ff) |=> o_ch2_on)
        else $error("Channel two off although enabled with sane limits.");

    offset_sel_a: assert property (
        wr_ctrl2_w |=> (o_ch2_offset_sel == $past(i_wdata[1:0]))[*1] ##1
        (o_ch2_offset_sel == $past(i_wdata[1:0], 2)) || $past(wr_ctrl2_w))
        else $error("Offset select does not follow the control write.");

    passthrough_a: assert property (
        code2_write_s ##1 (code2_ff >= lower2_ff && code2_ff <= upper2_ff && !wr_code2_w)
        |=> (o_ch2_code == $past(code2_ff)) && (code2_ff == $past(i_wdata, 2)))
        else $error("In-range code was altered on its way to the converter.");

    load_bound_a: assert property (
        $fell(i_rst) |-> ##[1:12] loaded_w)
        else $error("Startup limit load did not finish in time.");

    ctrl_read_a: assert property (
        (i_rd && hit(i_addr, `DLC_ADDR_CH2_CTRL)) |=> (o_rdata[7:3] == 5'h00))
        else $error("Unused control bits read back non-zero.");

endmodule // dlc_top
`default_nettype wire

// ==== test/dlc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defines.svh"

module dlc_top_tb
    import dlc_pkg::*;
;
    // ------------------------------------------------------------------------
    // Clock, reset and stimulus signals
    // ------------------------------------------------------------------------
    localparam int MAX_CYCLES = 3000;

    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    dlc_byte_t  i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    dlc_byte_t  o_rdata;
    dlc_byte_t  o_ch1_code;
    logic       o_ch1_on;
    dlc_byte_t  o_ch2_code;
    logic       o_ch2_on;
    logic [1:0] o_ch2_offset_sel;
    logic       o_load_done;
    int         num_errors = 0;
    int         n_compared = 0;
    int         cycles = 0;

    // The half period of 10 ns gives the 50 MHz device clock.
    always #10 i_clk = ~i_clk;

    dlc_top dut (
        .i_clk            (i_clk),
        .i_rst            (i_rst),
        .i_addr           (i_addr),
        .i_wdata          (i_wdata),
        .i_wr             (i_wr),
        .i_rd             (i_rd),
        .o_rdata          (o_rdata),
        .o_ch1_code       (o_ch1_code),
        .o_ch1_on         (o_ch1_on),
        .o_ch2_code       (o_ch2_code),
        .o_ch2_on         (o_ch2_on),
        .o_ch2_offset_sel (o_ch2_offset_sel),
        .o_load_done      (o_load_done)
    );

    // ------------------------------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------------------------------
    // A hang in the loader or the bus would stall the run, so cycles are capped.
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == MAX_CYCLES) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end

    task automatic conclude();
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One write cycle; the strobe drops at the edge that takes it.
    task automatic wr(input logic [7:0] a, input dlc_byte_t d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just there.
    task automatic rd(input logic [7:0] a, input string what, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        chk(what, exp, o_rdata);
    endtask

    // Converter codes and on flags follow a register change by one cycle.
    task automatic settle();
        @(posedge i_clk);
        #1;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    // Startup state and the limit image loaded before software acts.
    task automatic t_startup();
        int n;
        // Until the image lands, the reset upper limit pulls the midcode down.
        chk("ch1_code_rst", `DLC_RST_UPPER, o_ch1_code);
        chk("ch2_on_rst", 8'h00, {7'h00, o_ch2_on});
        n = 0;
        while (o_load_done !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            #1;
            n = n + 1;
        end
        chk("load_done", 8'h01, {7'h00, o_load_done});
        rd(`DLC_ADDR_CH1_UPPER, "ch1_upper", `DLC_NV_UPPER);
        rd(`DLC_ADDR_CH2_UPPER, "ch2_upper", `DLC_NV_UPPER);
        rd(`DLC_ADDR_CH1_LOWER, "ch1_lower", `DLC_NV_LOWER);
        rd(`DLC_ADDR_CH2_LOWER, "ch2_lower", `DLC_NV_LOWER);
        rd(`DLC_ADDR_CH1_CODE, "ch1_code_reg", 8'h7f);
        rd(`DLC_ADDR_CH2_CTRL, "ctrl_rst", 8'h00);
        chk("ch1_code_loaded", 8'h7f, o_ch1_code);
        chk("ch1_on_loaded", 8'h01, {7'h00, o_ch1_on});
        chk("ch2_off_ctrl", 8'h00, {7'h00, o_ch2_on});
    endtask

    // Unused control bits drop, every offset code reaches the output.
    task automatic t_control();
        logic [7:0] v;
        wr(`DLC_ADDR_CH2_CTRL, 8'hff);
        settle();
        rd(`DLC_ADDR_CH2_CTRL, "ctrl_masked", 8'h07);
        chk("ch2_on_enabled", 8'h01, {7'h00, o_ch2_on});
        for (int k = 0; k < 4; k++) begin
            v = 8'hf8 | 8'(k);
            wr(`DLC_ADDR_CH2_CTRL, v);
            settle();
            chk("offset_sel", 8'(k), {6'h00, o_ch2_offset_sel});
            chk("ch2_off_bit2", 8'h00, {7'h00, o_ch2_on});
        end
        wr(`DLC_ADDR_CH2_CTRL, 8'h04);
        settle();
        chk("ch2_on_again", 8'h01, {7'h00, o_ch2_on});
    endtask

    // Clamping on one channel: above, below, within, and crossed limits.
    task automatic t_clamp(input logic [7:0] code_a, input logic [7:0] up_a,
                           input logic [7:0] lo_a, input bit ch2);
        wr(up_a, 8'h10);
        wr(code_a, 8'h80);
        settle();
        chk("code_upper", 8'h10, ch2 ? o_ch2_code : o_ch1_code);
        rd(code_a, "code_kept", 8'h80);
        wr(up_a, 8'hf0);
        wr(lo_a, 8'h20);
        wr(code_a, 8'h05);
        settle();
        chk("code_lower", 8'h20, ch2 ? o_ch2_code : o_ch1_code);
        rd(code_a, "code_kept_lo", 8'h05);
        wr(code_a, 8'hf0);
        settle();
        chk("code_at_upper", 8'hf0, ch2 ? o_ch2_code : o_ch1_code);
        wr(code_a, 8'h20);
        settle();
        chk("code_at_lower", 8'h20, ch2 ? o_ch2_code : o_ch1_code);
        chk("on_normal", 8'h01, {7'h00, ch2 ? o_ch2_on : o_ch1_on});
        wr(lo_a, 8'hf1);
        settle();
        chk("on_crossed", 8'h00, {7'h00, ch2 ? o_ch2_on : o_ch1_on});
        wr(lo_a, 8'hf0);
        settle();
        chk("on_equal", 8'h01, {7'h00, ch2 ? o_ch2_on : o_ch1_on});
    endtask

    // Back-to-back strobes, an unmapped read and the status byte.
    task automatic t_map();
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= `DLC_ADDR_CH2_CODE;
        i_wdata <= 8'h33;
        @(posedge i_clk);
        i_wr    <= 1'b0;
        i_rd    <= 1'b1;
        @(posedge i_clk);
        i_rd    <= 1'b0;
        #1;
        chk("b2b_read", 8'h33, o_rdata);
        @(posedge i_clk);
        #1;
        chk("rdata_idle", 8'h00, o_rdata);
        wr(8'h55, 8'haa);
        rd(8'h55, "unmapped", 8'h00);
        rd(`DLC_ADDR_STATUS, "status", 8'h07);
    endtask

    // A reset in mid-run must reset channel one's outputs, the load flag and the offset select, and rerun the limit load.
    task automatic t_rerun();
        int n;
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        chk("code_in_rst", `DLC_RST_CODE, o_ch1_code);
        chk("ch1_on_in_rst", 8'h00, {7'h00, o_ch1_on});
        chk("load_in_rst", 8'h00, {7'h00, o_load_done});
        chk("offset_in_rst", 8'h00, {6'h00, o_ch2_offset_sel});
        @(posedge i_clk);
        i_rst <= 1'b0;
        n = 0;
        while (o_load_done !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            #1;
            n = n + 1;
        end
        chk("reload_done", 8'h01, {7'h00, o_load_done});
        rd(`DLC_ADDR_CH1_LOWER, "ch1_lower_again", `DLC_NV_LOWER);
        rd(`DLC_ADDR_CH2_UPPER, "ch2_upper_again", `DLC_NV_UPPER);
        rd(`DLC_ADDR_CH2_CODE, "ch2_code_again", 8'h7f);
        chk("ch2_out_again", 8'h7f, o_ch2_code);
        chk("ch2_off_again", 8'h00, {7'h00, o_ch2_on});
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        settle();
        t_startup();
        t_control();
        t_clamp(`DLC_ADDR_CH1_CODE, `DLC_ADDR_CH1_UPPER, `DLC_ADDR_CH1_LOWER, 1'b0);
        t_clamp(`DLC_ADDR_CH2_CODE, `DLC_ADDR_CH2_UPPER, `DLC_ADDR_CH2_LOWER, 1'b1);
        t_map();
        t_rerun();
        conclude();
    end

endmodule // dlc_top_tb

`default_nettype wire
